//--- logic/aep_pkg.sv
/*
 package of the absolute-encoder position block: register map, fields,
 reset values, usage-mode enum and the encoder sample carrier.
 assumes one pclk domain; encoder samples come from a receiver on pclk.
*/
// How it works
// RULE1 - keep 16-bit signed revolution count
// RULE2 - single-turn resolution 17 or 24 bits
// RULE3 - usage mode 0 incremental, 1 absolute
// RULE4 - incremental: no battery, re-home every power-up
// RULE5 - absolute: turns retained, home once; code also requires homing after every reset
// RULE6 - absolute: beyond 32767 turns flags overflow
// RULE7 - absolute: first battery power raises loss fault
// RULE8 - mechanical position = encoder minus zero offset
// RULE9 - incremental homing zeroes encoder position
// RULE10 - absolute homing keeps encoder position
// RULE11 - segment targets are mechanical positions
// RULE12 - low battery voltage raises its fault
// RULE13 - encoder type 0..12, stopped, after reset
// RULE14 - zero offset readable as two words
// RULE15 - mask bit0 alarm, bit1 failure suppress
// RULE16 - overflow checked each update, latched till cleared
`default_nettype none
package aep_pkg;
    localparam logic [7:0] ADDR_TYPE = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_ZLO  = 8'h08;
    localparam logic [7:0] ADDR_ZHI  = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_MECH = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQM = 8'h1c;
    localparam logic [7:0] ADDR_CTRL = 8'h20;
    localparam logic [7:0] ADDR_ELO  = 8'h24;
    localparam logic [7:0] ADDR_EHI  = 8'h28;

    localparam logic [15:0] TYPE_RST  = 16'h0000;
    localparam logic [15:0] TYPE_MAX  = 16'h000c;
    localparam logic [15:0] TYPE_RES24 = 16'h0002;
    localparam logic [3:0]  IRQM_RST  = 4'h0;
    localparam logic [15:0] TURN_BEYOND = 16'h8000;

    localparam int ST_OVF  = 0;
    localparam int ST_LOSS = 1;
    localparam int ST_VLOW = 2;
    localparam int ST_HOME = 3;
    localparam int CTRL_APPLY = 0;
    localparam int CTRL_CLR   = 1;
    localparam int MASK_ALARM = 0;
    localparam int MASK_FAIL  = 1;

    typedef enum logic {
        AEP_INCR,
        AEP_ABS
    } aep_mode_e;

    typedef struct packed {
        logic        valid;
        logic        bat_first;
        logic        bat_low;
        logic [15:0] turns;
        logic [23:0] single;
    } aep_sample_s;
endpackage : aep_pkg
`default_nettype wire

//--- logic/aep_position.sv
/*
 absolute-encoder position bookkeeping with an APB register slave.
 assumes samples, homing strobe and stopped flag come from pclk logic;
 the battery mask strap is a pin and is synchronised.
*/
`timescale 1ns/10ps
`default_nettype none
module aep_position (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // encoder side
    input  wire aep_pkg::aep_sample_s sample,
    input  wire logic [1:0]         mask_strap,
    // motion side
    input  wire logic               home_done,
    input  wire logic               stopped,
    input  wire logic [31:0]        seg_target,
    output logic [63:0]             seg_target_enc,
    output logic [31:0]             mech_pos,
    output logic                    abs_mode,
    output logic [15:0]             enc_type_active,
    output logic                    homing_required,
    // faults and interrupt
    output logic                    overflow_fault,
    output logic                    battery_power_loss_fault,
    output logic                    battery_voltage_low_fault,
    output logic                    irq
);
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= aep_pkg::ADDR_EHI) && (a[1:0] == 2'b00);
    endfunction : mapped

    function automatic logic [63:0] raw_pos(input logic [15:0] t,
                                            input logic [23:0] s,
                                            input logic        r24);
        raw_pos = r24 ? {{24{t[15]}}, t, s}
                      : {{31{t[15]}}, t, s[16:0]};
    endfunction : raw_pos

    logic [15:0] type_reg;
    logic [3:0]  irqm_reg;
    logic [3:0]  stat_reg;
    logic [3:0]  stat_next;
    logic [1:0]  mask_s1_reg;
    logic [1:0]  mask_reg;
    logic [63:0] raw_reg;
    logic [63:0] base_reg;
    logic [63:0] enc_reg;
    logic [63:0] off_reg;
    logic [63:0] raw_now;
    logic [63:0] enc_now;
    logic [63:0] mech64;
    logic        wr_acc;
    logic        rd_acc;
    logic        res24;
    logic        ovf_hit;
    logic        loss_hit;
    logic        vlow_hit;
    logic        clr_wr;
    logic [31:0] rd_mux;

    // apb: setup sampled, answer in first access cycle
    assign wr_acc = psel & penable & pready & pwrite;
    assign rd_acc = psel & penable & pready & ~pwrite;
    assign clr_wr = wr_acc && paddr == aep_pkg::ADDR_CTRL
                    && pwdata[aep_pkg::CTRL_CLR];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped(paddr);
            if (psel & ~penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            aep_pkg::ADDR_TYPE: rd_mux = {16'h0000, type_reg};
            aep_pkg::ADDR_MODE: rd_mux = {31'h0, abs_mode};
            aep_pkg::ADDR_ZLO:  rd_mux = off_reg[31:0]; // RULE14
            aep_pkg::ADDR_ZHI:  rd_mux = off_reg[63:32]; // RULE14
            aep_pkg::ADDR_MASK: rd_mux = {30'h0, mask_reg};
            aep_pkg::ADDR_MECH: rd_mux = mech_pos;
            aep_pkg::ADDR_STAT: rd_mux = {28'h0, stat_reg};
            aep_pkg::ADDR_IRQM: rd_mux = {28'h0, irqm_reg};
            aep_pkg::ADDR_ELO:  rd_mux = enc_reg[31:0];
            aep_pkg::ADDR_EHI:  rd_mux = enc_reg[63:32];
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // type only while stopped and in range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            type_reg <= aep_pkg::TYPE_RST;
        end else if (wr_acc && paddr == aep_pkg::ADDR_TYPE && stopped
                     && pwdata[15:0] <= aep_pkg::TYPE_MAX) begin
            // out-of-range codes dropped so the decode never sees them
            type_reg <= pwdata[15:0]; // RULE13
        end
    end

    // new type waits for the soft reset strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_type_active <= aep_pkg::TYPE_RST;
        end else if (wr_acc && paddr == aep_pkg::ADDR_CTRL
                     && pwdata[aep_pkg::CTRL_APPLY] && stopped) begin
            enc_type_active <= type_reg; // RULE13
        end
    end

    // usage mode switches at once, even while moving
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abs_mode <= 1'b0;
        end else if (wr_acc && paddr == aep_pkg::ADDR_MODE) begin
            abs_mode <= pwdata[0]; // RULE3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqm_reg <= aep_pkg::IRQM_RST;
        end else if (wr_acc && paddr == aep_pkg::ADDR_IRQM) begin
            irqm_reg <= pwdata[3:0];
        end
    end

    // strap pin crossing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_s1_reg <= 2'b00;
            mask_reg    <= 2'b00;
        end else begin
            mask_s1_reg <= mask_strap;
            mask_reg    <= mask_s1_reg;
        end
    end

    assign res24   = (enc_type_active == aep_pkg::TYPE_RES24); // RULE2
    assign raw_now = raw_pos(sample.turns, sample.single, res24); // RULE1
    assign enc_now = abs_mode ? raw_now : raw_now - base_reg;
    // incremental mode ignores battery and turn limits
    assign ovf_hit = sample.valid && abs_mode
                     && sample.turns == aep_pkg::TURN_BEYOND; // RULE6 RULE16
    assign loss_hit = sample.valid && abs_mode && sample.bat_first
                      && !mask_reg[aep_pkg::MASK_FAIL]; // RULE7 RULE15 RULE4
    assign vlow_hit = sample.valid && abs_mode && sample.bat_low
                      && !mask_reg[aep_pkg::MASK_ALARM]; // RULE12 RULE15
    assign mech64 = enc_reg - off_reg; // RULE8

    // position tracking and homing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_reg   <= 64'h0;
            base_reg  <= 64'h0;
            enc_reg   <= 64'h0;
            off_reg   <= 64'h0;
        end else if (home_done) begin
            if (abs_mode) begin
                off_reg <= enc_reg; // RULE10 RULE8
            end else begin
                base_reg <= raw_reg;
                enc_reg  <= 64'h0; // RULE9
                off_reg  <= 64'h0; // RULE9
            end
        end else if (sample.valid) begin
            raw_reg   <= raw_now; // RULE1
            enc_reg   <= enc_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mech_pos       <= 32'h0000_0000;
            seg_target_enc <= 64'h0;
        end else begin
            mech_pos       <= mech64[31:0]; // RULE8
            seg_target_enc <= {{32{seg_target[31]}}, seg_target}
                              + off_reg; // RULE11
        end
    end

    // both modes re-home after power-up; absolute also after loss
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            homing_required <= 1'b1;
        end else if (loss_hit || (!abs_mode && sample.valid
                     && homing_required)) begin
            homing_required <= 1'b1; // RULE5
        end else if (home_done) begin
            homing_required <= 1'b0; // RULE4 RULE5
        end
    end

    // latched faults: set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_fault <= 1'b0;
        end else begin
            overflow_fault <= ovf_hit | (overflow_fault & ~clr_wr); // RULE16
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            battery_power_loss_fault <= 1'b0;
        end else begin
            battery_power_loss_fault <= loss_hit | (battery_power_loss_fault & ~clr_wr); // RULE7
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            battery_voltage_low_fault <= 1'b0;
        end else begin
            battery_voltage_low_fault <= vlow_hit | (battery_voltage_low_fault & ~clr_wr); // RULE12
        end
    end

    // sticky status, cleared by reading it
    always_comb begin
        stat_next = stat_reg;
        // clear only what the read showed, so an event in between survives
        if (rd_acc && paddr == aep_pkg::ADDR_STAT) begin
            stat_next = stat_reg & ~prdata[3:0];
        end
        stat_next[aep_pkg::ST_OVF]  = stat_next[aep_pkg::ST_OVF] | ovf_hit;
        stat_next[aep_pkg::ST_LOSS] = stat_next[aep_pkg::ST_LOSS] | loss_hit;
        stat_next[aep_pkg::ST_VLOW] = stat_next[aep_pkg::ST_VLOW] | vlow_hit;
        stat_next[aep_pkg::ST_HOME] = stat_next[aep_pkg::ST_HOME] | home_done;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= 4'h0;
            irq      <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq      <= |(stat_next & irqm_reg);
        end
    end

    // bus and register checks
    AST_APB_RDY: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("access cycle without ready");

    AST_APB_ONE: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held beyond one cycle");

    AST_SLVERR: assert property (
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error response without ready");

    AST_MODE_NOW: assert property ( // RULE3
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == aep_pkg::ADDR_MODE |=> abs_mode == $past(pwdata[0]))
        else $error("usage mode not applied at once");

    AST_TYPE_RUN: assert property ( // RULE13
        @(posedge pclk) disable iff (!presetn)
        !stopped |=> $stable(type_reg))
        else $error("encoder type changed while running");

    AST_TYPE_ACT: assert property ( // RULE13
        @(posedge pclk) disable iff (!presetn)
        !(wr_acc && paddr == aep_pkg::ADDR_CTRL) |=> $stable(enc_type_active))
        else $error("active type changed without apply");

    // position checks
    AST_INC_HOME: assert property ( // RULE9
        @(posedge pclk) disable iff (!presetn)
        home_done && !abs_mode |=> enc_reg == 64'h0 && off_reg == 64'h0
        ##1 mech_pos == 32'h0000_0000)
        else $error("incremental homing did not zero");

    AST_ABS_HOME: assert property ( // RULE10
        @(posedge pclk) disable iff (!presetn)
        home_done && abs_mode |=> off_reg == $past(enc_reg)
        && enc_reg == $past(enc_reg))
        else $error("absolute homing altered position");

    AST_MECH: assert property ( // RULE8
        @(posedge pclk) disable iff (!presetn)
        ##1 mech_pos == $past(enc_reg[31:0]) - $past(off_reg[31:0]))
        else $error("mechanical position wrong");

    AST_SEG: assert property ( // RULE11
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> seg_target_enc == {{32{$past(seg_target[31])}}, $past(seg_target)}
        + $past(off_reg))
        else $error("segment target not offset");

    // fault and status checks
    AST_OVF_SET: assert property ( // RULE6
        @(posedge pclk) disable iff (!presetn)
        sample.valid && abs_mode && sample.turns == aep_pkg::TURN_BEYOND
        |=> overflow_fault && stat_reg[aep_pkg::ST_OVF])
        else $error("overflow not flagged");

    AST_OVF_HOLD: assert property ( // RULE16
        @(posedge pclk) disable iff (!presetn)
        overflow_fault && !clr_wr |=> overflow_fault)
        else $error("overflow fault dropped");

    AST_LOSS: assert property ( // RULE7
        @(posedge pclk) disable iff (!presetn)
        sample.valid && abs_mode && sample.bat_first
        && !mask_reg[aep_pkg::MASK_FAIL] |=> battery_power_loss_fault)
        else $error("battery loss not raised");

    AST_HOME_LOSS: assert property ( // RULE5
        @(posedge pclk) disable iff (!presetn)
        loss_hit |=> homing_required)
        else $error("battery loss did not request homing");

    AST_VLOW: assert property ( // RULE12
        @(posedge pclk) disable iff (!presetn)
        sample.valid && abs_mode && sample.bat_low
        && !mask_reg[aep_pkg::MASK_ALARM] |=> battery_voltage_low_fault)
        else $error("battery low not raised");

    AST_MASKED: assert property ( // RULE15
        @(posedge pclk) disable iff (!presetn)
        !battery_voltage_low_fault && mask_reg[aep_pkg::MASK_ALARM]
        |=> !battery_voltage_low_fault)
        else $error("masked battery alarm raised");

    AST_INC_QUIET: assert property ( // RULE4
        @(posedge pclk) disable iff (!presetn)
        !abs_mode && !battery_power_loss_fault
        |=> !battery_power_loss_fault)
        else $error("battery loss raised in incremental mode");

    AST_STAT_CLR: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_acc && paddr == aep_pkg::ADDR_STAT && prdata[aep_pkg::ST_OVF] && !ovf_hit
        |=> !stat_reg[aep_pkg::ST_OVF])
        else $error("status bit not cleared by read");

    AST_IRQ: assert property (
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> irq == |(stat_reg & $past(irqm_reg)))
        else $error("interrupt level wrong");

    // main scenarios
    CV_INC_HOME: cover property (@(posedge pclk) disable iff (!presetn)
        home_done && !abs_mode);
    CV_ABS_HOME: cover property (@(posedge pclk) disable iff (!presetn)
        home_done && abs_mode);
    CV_OVF: cover property (@(posedge pclk) disable iff (!presetn)
        ovf_hit ##[1:20] clr_wr);
    CV_LOSS: cover property (@(posedge pclk) disable iff (!presetn)
        loss_hit ##1 homing_required);
    CV_STAT_RD: cover property (@(posedge pclk) disable iff (!presetn)
        irq ##1 rd_acc && paddr == aep_pkg::ADDR_STAT);
endmodule : aep_position
`default_nettype wire

//--- verif/aep_enc_model.sv
/*
 encoder partner: turns each go pulse from the bench into one sample beat.
 assumes the bench drives go and the fields just after pclk rising edges.
*/
`timescale 1ns/10ps
`default_nettype none
module aep_enc_model (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // request from bench
    input  wire logic             go,
    input  wire logic [15:0]      turns,
    input  wire logic [23:0]      single,
    input  wire logic [1:0]       bat,
    // sample to device
    output var aep_pkg::aep_sample_s sample
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample <= '0;
        end else if (go) begin
            sample <= {1'b1, bat, turns, single};
        end else begin
            // idle beat scrambles fields so no stale value looks valid
            sample <= {1'b0, ~sample.bat_first, ~sample.bat_low, ~sample.turns, ~sample.single};
        end
    end
endmodule : aep_enc_model
`default_nettype wire

//--- verif/tb_top.sv
/*
 tb_top: apb master, encoder partner and integer model for aep_position.
 assumes a 20 MHz pclk and apb answers within twenty cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, go, err;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, rd, seg_target, mech_pos;
    logic [63:0]          seg_target_enc, enc_m, off_m;
    logic [15:0]          turns, enc_type_active, t;
    logic [23:0]          single;
    logic [1:0]           bat, mask_strap;
    logic                 home_done, stopped, abs_mode, homing_required, irq;
    logic                 overflow_fault, battery_power_loss_fault, battery_voltage_low_fault;
    aep_pkg::aep_sample_s sample;
    int                   mismatches, checked, res, i;

    aep_position dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .sample, .mask_strap, .home_done, .stopped, .seg_target,
        .seg_target_enc, .mech_pos, .abs_mode, .enc_type_active, .homing_required,
        .overflow_fault, .battery_power_loss_fault, .battery_voltage_low_fault, .irq);
    aep_enc_model enc (.pclk, .presetn, .go, .turns, .single, .bat, .sample);

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : apb

    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc

    task automatic send(input logic [15:0] tt, input logic [23:0] s, input logic [1:0] b);
        @(posedge pclk);
        go <= 1'b1;
        turns <= tt;
        single <= s;
        bat <= b;
        @(posedge pclk);
        go <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : send

    task automatic pulse_home;
        @(posedge pclk);
        home_done <= 1'b1;
        @(posedge pclk);
        home_done <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : pulse_home

    function automatic logic [63:0] pos(input logic [15:0] tt, input logic [23:0] s);
        logic [63:0] m;
        m = (64'h1 << res) - 64'h1;
        return ({{48{tt[15]}}, tt} << res) | ({40'h0, s} & m);
    endfunction : pos

    task automatic cpos;
        rdc("enc_lo", aep_pkg::ADDR_ELO, enc_m[31:0]);
        rdc("enc_hi", aep_pkg::ADDR_EHI, enc_m[63:32]);
        chk("mech_pos", {32'h0, enc_m[31:0] - off_m[31:0]}, {32'h0, mech_pos});
        rdc("mech_reg", aep_pkg::ADDR_MECH, enc_m[31:0] - off_m[31:0]);
    endtask : cpos

    initial begin
        void'($urandom(72304));
        {presetn, psel, penable, pwrite, go, home_done} = '0;
        {paddr, pwdata, turns, single, bat, mask_strap, seg_target} = '0;
        stopped = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        res = 17;
        enc_m = '0;
        off_m = '0;
        rdc("type_rst", aep_pkg::ADDR_TYPE, 32'h0);
        rdc("mode_rst", aep_pkg::ADDR_MODE, 32'h0);
        chk("home_req", 1, homing_required);
        apb(1'b0, 8'h2c, 32'h0);
        chk("slverr", 1, err);
        $display("test reset done");
        send(16'h0001, 24'h000005, 2'b11);
        chk("loss_incr", 0, battery_power_loss_fault);
        chk("vlow_incr", 0, battery_voltage_low_fault);
        enc_m = pos(16'h0001, 24'h000005);
        cpos();
        pulse_home();
        enc_m = '0;
        cpos();
        chk("home_req_clr", 0, homing_required);
        $display("test incremental done");
        apb(1'b1, aep_pkg::ADDR_MODE, 32'h1);
        chk("abs_mode", 1, abs_mode);
        for (i = 0; i < 3; i++) begin
            stopped <= (i != 0);
            apb(1'b1, aep_pkg::ADDR_TYPE, (i == 1) ? 32'hd : 32'h2);
            stopped <= 1'b1;
            apb(1'b1, aep_pkg::ADDR_CTRL, 32'h1);
            chk("type_active", (i == 2) ? 2 : 0, enc_type_active);
        end
        res = 24;
        $display("test mode and type done");
        for (i = 0; i < 5; i++) begin
            t = 16'($urandom);
            if (t == 16'h8000) t = 16'h0;
            send(t, 24'($urandom), 2'b00);
            enc_m = pos(t, single);
            cpos();
            if (i == 3) begin
                pulse_home();
                off_m = enc_m;
                rdc("zero_lo", aep_pkg::ADDR_ZLO, off_m[31:0]);
                rdc("zero_hi", aep_pkg::ADDR_ZHI, off_m[63:32]);
                cpos();
            end
        end
        seg_target <= $urandom;
        repeat (3) @(posedge pclk);
        chk("seg_enc", {{32{seg_target[31]}}, seg_target} + off_m, seg_target_enc);
        $display("test absolute done");
        apb(1'b1, aep_pkg::ADDR_IRQM, 32'h1);
        send(16'h8000, 24'h0, 2'b00);
        chk("ovf", 1, overflow_fault);
        chk("irq_on", 1, irq);
        apb(1'b0, aep_pkg::ADDR_STAT, 32'h0);
        chk("stat_ovf", 1, rd & 32'h7);
        chk("irq_off", 0, irq);
        chk("ovf_held", 1, overflow_fault);
        apb(1'b1, aep_pkg::ADDR_CTRL, 32'h2);
        chk("ovf_clr", 0, overflow_fault);
        send(16'h0, 24'h0, 2'b10);
        chk("loss", 1, battery_power_loss_fault);
        chk("home_req_loss", 1, homing_required);
        send(16'h0, 24'h0, 2'b01);
        chk("vlow", 1, battery_voltage_low_fault);
        chk("irq_masked", 0, irq);
        rdc("stat_bat", aep_pkg::ADDR_STAT, 32'h6);
        $display("test faults done");
        mask_strap <= 2'b11;
        apb(1'b1, aep_pkg::ADDR_CTRL, 32'h2);
        rdc("mask", aep_pkg::ADDR_MASK, 32'h3);
        send(16'h0, 24'h0, 2'b11);
        chk("loss_mask", 0, battery_power_loss_fault);
        chk("vlow_mask", 0, battery_voltage_low_fault);
        $display("test mask done");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
